// file: verilog/pulse_duration_modulator.sv
// Purpose: Stepped pulse duration modulator with three- and two-step modes
// Assumes: Single 25 MHz clock, registers reached over a plain port
// Notes:   One modulation step per step-enable pulse from the divider
//
// Decided for this implementation: the placing of the registers and the strobed register port.
`timescale 1ns/1ns
`default_nettype none

module pulse_duration_modulator
	import pdm_pkg::*;
#(
	parameter int STEP_DIV = STEP_CYCLES
)
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr_stb,
	input wire logic rd_stb,
	output logic [31:0] rdata,
	output logic positive_pulse_out,
	output logic negative_pulse_out
);

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [CTRL_W-1:0] ctrl_r;
	logic signed [7:0] demand_percent;
	logic [15:0] period_time;
	logic [15:0] min_pulse_break_time;
	logic [11:0] neg_pos_ratio;
	logic [31:0] rdata_r;
	logic manual_select;
	logic three_step_select;
	logic bipolar_two_step_select;
	logic manual_positive_request;
	logic manual_negative_request;
	logic auto_sync_enable;
	logic restart_init;

	assign manual_select = ctrl_r[CTRL_MANUAL];
	assign three_step_select = ctrl_r[CTRL_THREE];
	assign bipolar_two_step_select = ctrl_r[CTRL_BIPOLAR];
	assign manual_positive_request = ctrl_r[CTRL_POS_REQ];
	assign manual_negative_request = ctrl_r[CTRL_NEG_REQ];
	assign auto_sync_enable = ctrl_r[CTRL_SYNC];
	assign restart_init = ctrl_r[CTRL_RESTART];

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			ctrl_r <= CTRL_RST;
			demand_percent <= DEMAND_RST;
			period_time <= PERIOD_RST;
			min_pulse_break_time <= MINPB_RST;
			neg_pos_ratio <= RATIO_ONE;
		end
		else if (wr_stb)
		begin
			case (addr)
				ADDR_CTRL: ctrl_r <= wdata[CTRL_W-1:0];
				ADDR_DEMAND: demand_percent <= wdata[7:0];
				ADDR_PERIOD: period_time <= wdata[15:0];
				ADDR_MINPB: min_pulse_break_time <= wdata[15:0];
				ADDR_RATIO: neg_pos_ratio <= wdata[11:0];
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Step divider
	// ----------------------------------------------------------------
	logic [31:0] div_r;
	logic step_en;

	// Environment picks a constant step rate
	assign step_en = (div_r == 32'(STEP_DIV - 1));

	always_ff @(posedge mclk)
	begin
		if (!rst_n || step_en)
			div_r <= 32'h00000000;
		else
			div_r <= div_r + 32'h00000001;
	end

	// ----------------------------------------------------------------
	// Mode decode
	// ----------------------------------------------------------------
	mode_t mode;

	always_comb
	begin
		if (manual_select)
			mode = MODE_MANUAL;
		else if (three_step_select)
			mode = MODE_THREE;
		else if (bipolar_two_step_select)
			mode = MODE_BIPOLAR;
		else
			mode = MODE_UNIPOLAR;
	end

	// ----------------------------------------------------------------
	// Pulse width calculation
	// ----------------------------------------------------------------
	logic [8:0] mag;
	logic [31:0] nominal;
	logic [31:0] thresh;
	logic [31:0] limit;
	logic [15:0] width_c;
	logic neg_c;
	logic [11:0] ratio_eff;

	always_comb
	begin
		ratio_eff = (neg_pos_ratio == 12'h000) ? RATIO_ONE : neg_pos_ratio;
		neg_c = 1'b0;
		thresh = {16'h0000, min_pulse_break_time};
		case (mode)
			MODE_BIPOLAR:
			begin
				if (demand_percent < -8'sd100)
					mag = 9'h000;
				else
					mag = 9'({demand_percent[7], demand_percent}) + PCT_OFFSET;
				nominal = (32'(mag) * 32'(period_time)) / PCT_SPAN;
			end
			MODE_UNIPOLAR:
			begin
				mag = demand_percent[7] ? 9'h000 : 9'(demand_percent);
				nominal = (32'(mag) * 32'(period_time)) / PCT_FULL;
			end
			default:
			begin
				neg_c = demand_percent[7];
				mag = neg_c ? 9'(-{demand_percent[7], demand_percent})
					: 9'(demand_percent);
				nominal = (32'(mag) * 32'(period_time)) / PCT_FULL;
				if (neg_c && ratio_eff < RATIO_ONE)
				begin
					nominal = (nominal * 32'(ratio_eff)) >> RATIO_FRAC;
					thresh = (thresh * 32'(ratio_eff)) >> RATIO_FRAC;
				end
				else if (!neg_c && ratio_eff > RATIO_ONE)
					nominal = (nominal << RATIO_FRAC) / 32'(ratio_eff);
			end
		endcase
		limit = (min_pulse_break_time > period_time) ? 32'h00000000
			: 32'(period_time - min_pulse_break_time);
		if (nominal < thresh)
			width_c = 16'h0000;
		else if (nominal > limit)
			width_c = period_time;
		else
			width_c = nominal[15:0];
	end

	// ----------------------------------------------------------------
	// Period sequencer
	// ----------------------------------------------------------------
	logic [15:0] cnt_r;
	logic [15:0] width_r;
	logic neg_dir_r;
	logic signed [7:0] sampled_r;
	logic start_r;
	logic sync_hit;
	logic period_start;

	// Outside the first two and last two steps a new demand restarts
	assign sync_hit = auto_sync_enable && (demand_percent != sampled_r)
		&& (cnt_r >= 16'h0002)
		&& (32'(cnt_r) + 32'h00000002 < 32'(period_time));
	assign period_start = start_r || sync_hit
		|| (32'(cnt_r) + 32'h00000001 >= 32'(period_time));

	always_ff @(posedge mclk)
	begin
		if (!rst_n || restart_init)
		begin
			cnt_r <= 16'h0000;
			width_r <= 16'h0000;
			neg_dir_r <= 1'b0;
			sampled_r <= DEMAND_RST;
			start_r <= 1'b1;
		end
		else if (step_en && mode != MODE_MANUAL)
		begin
			start_r <= 1'b0;
			if (period_start)
			begin
				cnt_r <= 16'h0000;
				width_r <= width_c;
				neg_dir_r <= neg_c;
				sampled_r <= demand_percent;
			end
			else
				cnt_r <= cnt_r + 16'h0001;
		end
	end

	// ----------------------------------------------------------------
	// Output stage
	// ----------------------------------------------------------------
	logic on_c;

	always_comb
	begin
		if (period_start)
			on_c = (width_c != 16'h0000);
		else
			on_c = (cnt_r + 16'h0001 < width_r);
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n || restart_init)
		begin
			positive_pulse_out <= 1'b0;
			negative_pulse_out <= 1'b0;
		end
		else if (mode == MODE_MANUAL)
		begin
			if (three_step_select)
			begin
				positive_pulse_out <= manual_positive_request
					&& !manual_negative_request;
				negative_pulse_out <= manual_negative_request
					&& !manual_positive_request;
			end
			else
			begin
				positive_pulse_out <= manual_positive_request;
				negative_pulse_out <= !manual_positive_request;
			end
		end
		else if (step_en)
		begin
			if (mode == MODE_THREE)
			begin
				positive_pulse_out <= on_c
					&& !(period_start ? neg_c : neg_dir_r);
				negative_pulse_out <= on_c
					&& (period_start ? neg_c : neg_dir_r);
			end
			else
			begin
				positive_pulse_out <= on_c;
				negative_pulse_out <= !on_c;
			end
		end
	end

	// ----------------------------------------------------------------
	// Register read port
	// ----------------------------------------------------------------
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			rdata_r <= 32'h00000000;
		else if (rd_stb)
		begin
			case (addr)
				ADDR_CTRL: rdata_r <= 32'(ctrl_r);
				ADDR_DEMAND: rdata_r <= {{24{demand_percent[7]}}, demand_percent};
				ADDR_PERIOD: rdata_r <= 32'(period_time);
				ADDR_MINPB: rdata_r <= 32'(min_pulse_break_time);
				ADDR_RATIO: rdata_r <= 32'(neg_pos_ratio);
				ADDR_STATUS: rdata_r <= {negative_pulse_out, positive_pulse_out,
					neg_dir_r, 13'h0000, cnt_r};
				default: rdata_r <= 32'h00000000;
			endcase
		end
		else
			rdata_r <= 32'h00000000;
	end

	assign rdata = rdata_r;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	property p_restart_clears;
		@(posedge mclk) disable iff (!rst_n)
		restart_init |=> !positive_pulse_out && !negative_pulse_out;
	endproperty
	a_restart_clears: assert property (p_restart_clears)
		else $error("Restart did not clear pulse outputs");

	property p_man3_single;
		@(posedge mclk) disable iff (!rst_n)
		(manual_select && three_step_select && !restart_init
			&& (manual_positive_request != manual_negative_request))
		|=> positive_pulse_out == $past(manual_positive_request)
			&& negative_pulse_out == $past(manual_negative_request);
	endproperty
	a_man3_single: assert property (p_man3_single)
		else $error("Manual three-step output does not follow request");

	property p_man3_both;
		@(posedge mclk) disable iff (!rst_n)
		(manual_select && three_step_select && !restart_init
			&& manual_positive_request && manual_negative_request)
		|=> !positive_pulse_out && !negative_pulse_out;
	endproperty
	a_man3_both: assert property (p_man3_both)
		else $error("Manual three-step with both requests not low");

	property p_man2;
		@(posedge mclk) disable iff (!rst_n)
		(manual_select && !three_step_select && !restart_init)
		|=> positive_pulse_out == $past(manual_positive_request)
			&& negative_pulse_out != positive_pulse_out;
	endproperty
	a_man2: assert property (p_man2)
		else $error("Manual two-step outputs wrong");

	property p_two_inverse;
		@(posedge mclk) disable iff (!rst_n)
		(step_en && !restart_init && !manual_select && !three_step_select)
		|=> negative_pulse_out != positive_pulse_out;
	endproperty
	a_two_inverse: assert property (p_two_inverse)
		else $error("Two-step negative output not inverse");

	property p_three_exclusive;
		@(posedge mclk) disable iff (!rst_n)
		(step_en && !restart_init && mode == MODE_THREE)
		|=> !(positive_pulse_out && negative_pulse_out)
			&& (negative_pulse_out -> neg_dir_r);
	endproperty
	a_three_exclusive: assert property (p_three_exclusive)
		else $error("Three-step drove wrong or both outputs");

	property p_width_steps;
		@(posedge mclk) disable iff (!rst_n)
		(step_en && !restart_init && !period_start && !manual_select
			&& !three_step_select)
		|=> positive_pulse_out == (cnt_r < width_r);
	endproperty
	a_width_steps: assert property (p_width_steps)
		else $error("Pulse length not in whole steps of width");

	property p_sync_restart;
		@(posedge mclk) disable iff (!rst_n)
		(step_en && sync_hit && !restart_init && !manual_select)
		|=> cnt_r == 16'h0000 && sampled_r == $past(demand_percent);
	endproperty
	a_sync_restart: assert property (p_sync_restart)
		else $error("Demand change did not restart the period");

	property p_free_run;
		@(posedge mclk) disable iff (!rst_n)
		(step_en && !auto_sync_enable && !restart_init && !start_r
			&& !manual_select
			&& (32'(cnt_r) + 32'h00000001 < 32'(period_time)))
		|=> cnt_r == $past(cnt_r) + 16'h0001;
	endproperty
	a_free_run: assert property (p_free_run)
		else $error("Period restarted while sync disabled");

	property p_suppress;
		@(posedge mclk) disable iff (!rst_n)
		(step_en && period_start && !restart_init && !manual_select
			&& nominal < thresh)
		|=> width_r == 16'h0000;
	endproperty
	a_suppress: assert property (p_suppress)
		else $error("Short pulse not suppressed");

	property p_saturate;
		@(posedge mclk) disable iff (!rst_n)
		(step_en && period_start && !restart_init && !manual_select
			&& nominal >= thresh && nominal > limit)
		|=> width_r == $past(period_time);
	endproperty
	a_saturate: assert property (p_saturate)
		else $error("Long pulse not forced to full period");

	property p_sample_hold;
		@(posedge mclk) disable iff (!rst_n)
		(!(step_en && period_start) && !restart_init) |=> $stable(sampled_r);
	endproperty
	a_sample_hold: assert property (p_sample_hold)
		else $error("Demand sampled outside a period start");

endmodule : pulse_duration_modulator

`default_nettype wire

// file: inc/pdm_pkg.sv
// Purpose: Shared constants for the pulse duration modulator
// Assumes: 25 MHz mclk, register port with 8-bit byte address
// Notes:   Percentages are signed whole numbers, times are in steps
package pdm_pkg;

	// ----------------------------------------------------------------
	// Clock and step timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 40;
	localparam int STEP_TIME_NS = 1000000;
	localparam int STEP_CYCLES = STEP_TIME_NS / CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_DEMAND = 8'h04;
	localparam logic [7:0] ADDR_PERIOD = 8'h08;
	localparam logic [7:0] ADDR_MINPB = 8'h0C;
	localparam logic [7:0] ADDR_RATIO = 8'h10;
	localparam logic [7:0] ADDR_STATUS = 8'h14;

	// ----------------------------------------------------------------
	// Control field positions
	// ----------------------------------------------------------------
	localparam int CTRL_MANUAL = 0;
	localparam int CTRL_THREE = 1;
	localparam int CTRL_BIPOLAR = 2;
	localparam int CTRL_POS_REQ = 3;
	localparam int CTRL_NEG_REQ = 4;
	localparam int CTRL_SYNC = 5;
	localparam int CTRL_RESTART = 6;
	localparam int CTRL_W = 7;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [6:0] CTRL_RST = 7'h22;
	localparam logic [7:0] DEMAND_RST = 8'h00;
	localparam logic [15:0] PERIOD_RST = 16'h0064;
	localparam logic [15:0] MINPB_RST = 16'h0000;
	localparam logic [11:0] RATIO_ONE = 12'h100;
	localparam int RATIO_FRAC = 8;

	// ----------------------------------------------------------------
	// Arithmetic constants
	// ----------------------------------------------------------------
	localparam logic [31:0] PCT_FULL = 32'h00000064;
	localparam logic [31:0] PCT_SPAN = 32'h000000C8;
	localparam logic [8:0] PCT_OFFSET = 9'h064;

	typedef enum {MODE_MANUAL, MODE_THREE, MODE_BIPOLAR, MODE_UNIPOLAR}
		mode_t;

endpackage : pdm_pkg

// file: bench/upstream_ctrl.sv
// Purpose: Upstream controller model that feeds the modulator its demand
// Assumes: One register access at a time, slave never waits
// Notes:   Read data is taken in the cycle after the read strobe
`timescale 1ns/1ns
`default_nettype none
module upstream_ctrl
(
	input wire logic mclk,
	output logic [7:0] addr,
	output logic [31:0] wdata,
	output logic wr_stb,
	output logic rd_stb,
	input wire logic [31:0] rdata
);
	// ------------------
	// Port master
	// ------------------
	initial
	begin
		addr = 8'h00;
		wdata = 32'h00000000;
		wr_stb = 1'b0;
		rd_stb = 1'b0;
	end

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr_stb <= 1'b1;
		@(posedge mclk);
		wr_stb <= 1'b0;
		// Released data no longer shows the last value
		wdata <= ~d;
	endtask : wr_reg

	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
		@(posedge mclk);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge mclk);
		rd_stb <= 1'b0;
		@(negedge mclk);
		d = rdata;
	endtask : rd_reg
endmodule : upstream_ctrl
`default_nettype wire

// file: bench/test_pulse_duration_modulator.sv
// Purpose: Self-checking bench for the pulse duration modulator
// Assumes: Four clocks per step, twenty steps per period
// Notes:   Widths are judged by high-cycle counts over one period
`timescale 1ns/1ns
`default_nettype none
module test_pulse_duration_modulator
	import pdm_pkg::*;
;
	localparam int DIV = 4;
	localparam int PER = 20;
	localparam int PCYC = DIV * PER;
	logic mclk;
	logic rst_n;
	logic [7:0] addr;
	logic [31:0] wdata;
	logic wr_stb;
	logic rd_stb;
	logic [31:0] rdata;
	logic positive_pulse_out;
	logic negative_pulse_out;
	int fails;
	int n_tests;

	initial
	begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	// Constant step rate from a fixed divider
	pulse_duration_modulator #(.STEP_DIV(DIV)) pulse_duration_modulator_i
	(
		.mclk(mclk),
		.rst_n(rst_n),
		.addr(addr),
		.wdata(wdata),
		.wr_stb(wr_stb),
		.rd_stb(rd_stb),
		.rdata(rdata),
		.positive_pulse_out(positive_pulse_out),
		.negative_pulse_out(negative_pulse_out)
	);

	upstream_ctrl upstream_ctrl_i
	(
		.mclk(mclk),
		.addr(addr),
		.wdata(wdata),
		.wr_stb(wr_stb),
		.rd_stb(rd_stb),
		.rdata(rdata)
	);

	// ------------------
	// Helpers
	// ------------------
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_tests++;
		if (g !== e)
		begin
			fails++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic chk_bit(input string nm, input logic e, input logic g);
		n_tests++;
		if (g !== e)
		begin
			fails++;
			$display("BAD %s expected %b seen %b", nm, e, g);
		end
	endtask : chk_bit

	task automatic print_verdict;
		if (fails == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : print_verdict

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		upstream_ctrl_i.wr_reg(a, d);
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		upstream_ctrl_i.rd_reg(a, d);
	endtask : rd

	task automatic run_case(input logic [31:0] ctl, input logic [31:0] dem,
		input logic [31:0] mpb, input logic [31:0] rat,
		input int ep, input int en);
		logic [31:0] pc;
		logic [31:0] nc;
		pc = 32'h0;
		nc = 32'h0;
		wr(ADDR_CTRL, ctl);
		wr(ADDR_MINPB, mpb);
		wr(ADDR_RATIO, rat);
		wr(ADDR_DEMAND, dem);
		repeat (2 * PCYC) @(negedge mclk);
		repeat (PCYC)
		begin
			@(negedge mclk);
			pc = pc + 32'(positive_pulse_out);
			nc = nc + 32'(negative_pulse_out);
		end
		chk("pos cycles", 32'(ep * DIV), pc);
		chk("neg cycles", 32'(en * DIV), nc);
	endtask : run_case

	task automatic man_case(input logic [31:0] ctl, input logic ep,
		input logic en);
		wr(ADDR_CTRL, ctl);
		repeat (2) @(negedge mclk);
		chk_bit("manual pos", ep, positive_pulse_out);
		chk_bit("manual neg", en, negative_pulse_out);
	endtask : man_case

	// ------------------
	// Scenarios
	// ------------------
	task automatic t_regs;
		logic [31:0] d;
		rd(ADDR_CTRL, d);
		chk("ctrl reset", 32'h22, d);
		rd(ADDR_PERIOD, d);
		chk("period reset", 32'h64, d);
		rd(8'h3C, d);
		chk("unmapped", 32'h0, d);
		wr(ADDR_DEMAND, 32'hD3);
		rd(ADDR_DEMAND, d);
		chk("demand", 32'hFFFFFFD3, d);
	endtask : t_regs

	task automatic t_three;
		run_case(32'h22, 32'h1E, 32'h0, 32'h100, 6, 0);
		run_case(32'h22, 32'h21, 32'h0, 32'h100, 6, 0);
		run_case(32'h22, 32'hD3, 32'h0, 32'h100, 0, 9);
		run_case(32'h22, 32'h0, 32'h0, 32'h100, 0, 0);
		run_case(32'h22, 32'h64, 32'h0, 32'h100, 20, 0);
		run_case(32'h26, 32'hD3, 32'h0, 32'h100, 0, 9);
	endtask : t_three

	task automatic t_limits;
		run_case(32'h22, 32'h0A, 32'h3, 32'h100, 0, 0);
		run_case(32'h22, 32'h0F, 32'h3, 32'h100, 3, 0);
		run_case(32'h22, 32'h55, 32'h3, 32'h100, 17, 0);
		run_case(32'h22, 32'h5A, 32'h3, 32'h100, 20, 0);
		run_case(32'h22, 32'hA6, 32'h3, 32'h100, 0, 20);
	endtask : t_limits

	task automatic t_ratio;
		run_case(32'h22, 32'hCE, 32'h0, 32'h080, 0, 5);
		run_case(32'h22, 32'h32, 32'h0, 32'h080, 10, 0);
		run_case(32'h22, 32'hE2, 32'h4, 32'h080, 0, 3);
		run_case(32'h22, 32'h32, 32'h0, 32'h200, 5, 0);
		run_case(32'h22, 32'hCE, 32'h0, 32'h200, 0, 10);
	endtask : t_ratio

	task automatic t_two;
		run_case(32'h24, 32'h1E, 32'h0, 32'h100, 13, 7);
		run_case(32'h24, 32'h9C, 32'h0, 32'h100, 0, 20);
		run_case(32'h24, 32'h0, 32'h0, 32'h100, 10, 10);
		run_case(32'h20, 32'hD8, 32'h0, 32'h100, 0, 20);
		run_case(32'h20, 32'h32, 32'h0, 32'h100, 10, 10);
	endtask : t_two

	task automatic t_manual;
		wr(ADDR_DEMAND, 32'h64);
		man_case(32'h23, 1'b0, 1'b0);
		man_case(32'h2B, 1'b1, 1'b0);
		man_case(32'h33, 1'b0, 1'b1);
		man_case(32'h3B, 1'b0, 1'b0);
		man_case(32'h21, 1'b0, 1'b1);
		man_case(32'h29, 1'b1, 1'b0);
		man_case(32'h31, 1'b0, 1'b1);
		man_case(32'h2F, 1'b1, 1'b0);
	endtask : t_manual

	task automatic t_restart;
		logic seen;
		seen = 1'b0;
		run_case(32'h22, 32'h64, 32'h0, 32'h100, 20, 0);
		wr(ADDR_CTRL, 32'h62);
		repeat (2) @(negedge mclk);
		repeat (PCYC)
		begin
			@(negedge mclk);
			seen = seen | positive_pulse_out | negative_pulse_out;
		end
		chk_bit("restart out", 1'b0, seen);
	endtask : t_restart

	task automatic t_sync(input logic [31:0] ctl, input logic fast);
		logic [31:0] d;
		logic rise;
		int k;
		d = 32'h0;
		rise = 1'b0;
		run_case(ctl, 32'h0, 32'h0, 32'h100, 0, 0);
		for (k = 0; k < 400 && d[15:0] !== 16'h000A; k++)
			rd(ADDR_STATUS, d);
		if (d[15:0] !== 16'h000A)
		begin
			fails++;
			print_verdict();
		end
		wr(ADDR_DEMAND, 32'h32);
		repeat (fast ? 8 : 24)
		begin
			@(negedge mclk);
			rise = rise | positive_pulse_out;
		end
		chk_bit("early pulse", fast, rise);
	endtask : t_sync

	// ------------------
	// Main sequence
	// ------------------
	initial
	begin
		rst_n = 1'b0;
		fails = 0;
		n_tests = 0;
		repeat (4) @(posedge mclk);
		rst_n <= 1'b1;
		t_regs();
		wr(ADDR_PERIOD, 32'(PER));
		t_three();
		t_limits();
		t_ratio();
		t_two();
		t_manual();
		t_restart();
		t_sync(32'h22, 1'b1);
		t_sync(32'h02, 1'b0);
		print_verdict();
	end
endmodule : test_pulse_duration_modulator
`default_nettype wire
